/* hw/ltm_device.sv */
// Line interface transmit side: rail sampling, line drive with shut-off,
// drive monitor, and a small register port with an event interrupt.
// Assumes every link pin is asynchronous to clk_i and is synchronised here.
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module ltm_device
  import ltm_pkg::*;
#(
  parameter int unsigned FAULT_PERIODS = LTM_FAULT_BIT_PERIODS
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  ltm_link_if.device_mp link,
  input wire logic host_mode_i,
  input wire logic [LTM_ADDR_W-1:0] reg_addr_i,
  input wire logic [LTM_DATA_W-1:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output logic [LTM_DATA_W-1:0] reg_rdata_o,
  output logic drive_fault_flag_o,
  output logic irq_o
);

  localparam int unsigned CNT_W = $clog2(FAULT_PERIODS);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(FAULT_PERIODS - 1);

  // Synchroniser lanes
  localparam int unsigned LN_CLK = 0;
  localparam int unsigned LN_POS = 1;
  localparam int unsigned LN_NEG = 2;
  localparam int unsigned LN_OFF = 3;
  localparam int unsigned LN_MON_A = 4;
  localparam int unsigned LN_MON_B = 5;
  localparam int unsigned LN_HOST = 6;
  localparam int unsigned LN_W = 7;

  typedef struct packed {
    logic [LTM_CTRL_W-1:0] ctrl;
    logic [LTM_EV_W-1:0] status;
    logic [LTM_EV_W-1:0] enable;
    logic [LTM_DATA_W-1:0] rdata;
    logic clk_prev;
    logic [1:0] mon_prev;
    ltm_sym_e sym;
    logic line_a;
    logic line_b;
    logic drive_oe;
    logic [CNT_W-1:0] quiet_cnt;
    logic fault;
    logic irq;
  } ltm_dev_s;

  ltm_dev_s q;
  ltm_dev_s d;

  logic [LN_W-1:0] pins_async;
  logic [LN_W-1:0] pins;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  assign pins_async[LN_CLK] = link.tx_line_clock;
  assign pins_async[LN_POS] = link.tx_positive_rail;
  assign pins_async[LN_NEG] = link.tx_negative_rail;
  assign pins_async[LN_OFF] = link.transmitter_off_input;
  assign pins_async[LN_MON_A] = link.monitor_in_a;
  assign pins_async[LN_MON_B] = link.monitor_in_b;
  assign pins_async[LN_HOST] = host_mode_i;

  ltm_sync3 #(
    .W(LN_W)
  ) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i(pins_async),
    .sync_o(pins)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  logic host;
  logic edge_rise;
  logic edge_fall;
  logic sample;
  logic neg_rail;
  logic line_off;
  logic mon_pulse;
  logic [LTM_EV_W-1:0] events;
  logic [LTM_EV_W-1:0] clear_mask;
  logic [LTM_DATA_W-1:0] state_word;

  always_comb begin
    d = q;
    events = '0;
    clear_mask = '0;
    state_word = '0;
    d.rdata = '0;

    host = pins[LN_HOST];
    edge_rise = pins[LN_CLK] & ~q.clk_prev;
    edge_fall = ~pins[LN_CLK] & q.clk_prev;
    d.clk_prev = pins[LN_CLK];

    sample = edge_fall;
    if (host && q.ctrl[LTM_CTRL_RISE_BIT]) begin
      sample = edge_rise;
    end

    neg_rail = q.ctrl[LTM_CTRL_SINGLE_BIT] ? 1'b0 : pins[LN_NEG];

    if (sample) begin
      unique case ({pins[LN_POS], neg_rail})
        2'b10: d.sym = LTM_SYM_POS;
        2'b01: d.sym = LTM_SYM_NEG;
        default: d.sym = LTM_SYM_ZERO;
      endcase
    end

    line_off = pins[LN_OFF] | q.ctrl[LTM_CTRL_OFF_BIT];
    d.drive_oe = ~line_off;
    d.line_a = ~line_off && (d.sym == LTM_SYM_POS);
    d.line_b = ~line_off && (d.sym == LTM_SYM_NEG);

    // Drive monitor
    mon_pulse = |(pins[LN_MON_B:LN_MON_A] & ~q.mon_prev);
    d.mon_prev = pins[LN_MON_B:LN_MON_A];
    if (mon_pulse) begin
      d.quiet_cnt = '0;
      d.fault = 1'b0;
      events[LTM_EV_FAULT_CLR] = q.fault;
    end else if (sample && !q.fault) begin
      if (q.quiet_cnt == CNT_LAST) begin
        d.fault = 1'b1;
        events[LTM_EV_FAULT_SET] = 1'b1;
      end else begin
        d.quiet_cnt = q.quiet_cnt + 1'b1;
      end
    end

    // Register writes
    if (reg_write_i) begin
      unique case (reg_addr_i)
        LTM_ADDR_CTRL: d.ctrl = reg_wdata_i[LTM_CTRL_W-1:0];
        LTM_ADDR_CLEAR: clear_mask = reg_wdata_i[LTM_EV_W-1:0];
        LTM_ADDR_ENABLE: d.enable = reg_wdata_i[LTM_EV_W-1:0];
        default: ;
      endcase
    end

    // Set wins over clear
    d.status = (q.status & ~clear_mask) | events;
    d.irq = |(d.status & d.enable);

    // Register reads, data valid one cycle later only
    state_word[LTM_ST_FAULT_BIT] = q.fault;
    state_word[LTM_ST_DRIVE_BIT] = q.drive_oe;
    state_word[LTM_ST_OFF_PIN_BIT] = pins[LN_OFF];
    state_word[LTM_ST_HOST_BIT] = host;
    if (reg_read_i) begin
      unique case (reg_addr_i)
        LTM_ADDR_CTRL: d.rdata = LTM_DATA_W'(q.ctrl);
        LTM_ADDR_STATUS: d.rdata = LTM_DATA_W'(q.status);
        LTM_ADDR_ENABLE: d.rdata = LTM_DATA_W'(q.enable);
        LTM_ADDR_STATE: d.rdata = state_word;
        default: d.rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
      q.ctrl <= LTM_CTRL_RESET[LTM_CTRL_W-1:0];
      q.sym <= LTM_SYM_ZERO;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign link.line_out_a = q.line_a;
  assign link.line_out_b = q.line_b;
  assign link.line_out_a_oe = q.drive_oe;
  assign link.line_out_b_oe = q.drive_oe;
  assign reg_rdata_o = q.rdata;
  assign drive_fault_flag_o = q.fault;
  assign irq_o = q.irq;

endmodule
`default_nettype wire

/* hw/ltm_link_if.sv */
// Pins between the terminal and the line interface transmit side.
// Assumes the line outputs loop back to the monitor inputs on the board.
`timescale 1ns/1ps
`default_nettype none
interface ltm_link_if;
  logic tx_line_clock;
  logic tx_positive_rail;
  logic tx_negative_rail;
  logic transmitter_off_input;
  logic line_out_a;
  logic line_out_a_oe;
  logic line_out_b;
  logic line_out_b_oe;
  logic monitor_used;
  logic monitor_in_a;
  logic monitor_in_b;

  // Board loop: a floating line reads low, an unused monitor is tied low
  assign monitor_in_a = monitor_used & line_out_a_oe & line_out_a;
  assign monitor_in_b = monitor_used & line_out_b_oe & line_out_b;

  modport device_mp (
    input tx_line_clock, tx_positive_rail, tx_negative_rail, transmitter_off_input,
    input monitor_in_a, monitor_in_b,
    output line_out_a, line_out_a_oe, line_out_b, line_out_b_oe
  );

  modport terminal_mp (
    output tx_line_clock, tx_positive_rail, tx_negative_rail, transmitter_off_input,
    output monitor_used,
    input line_out_a, line_out_a_oe, line_out_b, line_out_b_oe
  );
endinterface
`default_nettype wire

/* hw/ltm_pkg.sv */
// Shared constants and types for the transmit terminal link and drive monitor.
// Assumes a single 100 MHz system clock on both ends of the link.
//
// Contract
// - Either off source tri-states both line outputs.
// - Off pin still honoured in register mode.
// - Hold off pin low in register mode.
// - Terminal clock rate matches selected service; the terminal runs a fixed 8-cycle clock with no service select.
// - Rails sampled on falling clock edge by default.
// - Register mode may select rising-edge sampling.
// - Positive rail one gives positive line pulse.
// - Negative rail one gives negative line pulse.
// - Single-rail data goes on positive rail.
// - Single-rail ignores negative rail; terminal ties low.
// - Fault flag after 128 pulseless bit periods.
// - Unused monitor inputs are tied low.
package ltm_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register port
  localparam int unsigned LTM_ADDR_W = 4;
  localparam int unsigned LTM_DATA_W = 8;
  localparam logic [LTM_ADDR_W-1:0] LTM_ADDR_CTRL = 4'h0;
  localparam logic [LTM_ADDR_W-1:0] LTM_ADDR_STATUS = 4'h1;
  localparam logic [LTM_ADDR_W-1:0] LTM_ADDR_CLEAR = 4'h2;
  localparam logic [LTM_ADDR_W-1:0] LTM_ADDR_ENABLE = 4'h3;
  localparam logic [LTM_ADDR_W-1:0] LTM_ADDR_STATE = 4'h4;
  localparam logic [LTM_DATA_W-1:0] LTM_CTRL_RESET = 8'h00;

  // Control fields
  localparam int unsigned LTM_CTRL_OFF_BIT = 0;
  localparam int unsigned LTM_CTRL_RISE_BIT = 1;
  localparam int unsigned LTM_CTRL_SINGLE_BIT = 2;
  localparam int unsigned LTM_CTRL_W = 3;

  // Event fields of status, clear and enable
  localparam int unsigned LTM_EV_FAULT_SET = 0;
  localparam int unsigned LTM_EV_FAULT_CLR = 1;
  localparam int unsigned LTM_EV_W = 2;

  // Live state fields
  localparam int unsigned LTM_ST_FAULT_BIT = 0;
  localparam int unsigned LTM_ST_DRIVE_BIT = 1;
  localparam int unsigned LTM_ST_OFF_PIN_BIT = 2;
  localparam int unsigned LTM_ST_HOST_BIT = 3;

  //////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int unsigned LTM_FAULT_BIT_PERIODS = 128;
  localparam int unsigned LTM_CLK_KHZ = 100000;
  localparam int unsigned LTM_RATE_E3_KHZ = 34368;
  localparam int unsigned LTM_RATE_DS3_KHZ = 44736;
  localparam int unsigned LTM_RATE_STS1_KHZ = 51840;
  localparam int unsigned LTM_TERM_HALF_PERIOD = 4;

  // Symbol on the line outputs
  typedef enum logic [1:0] {
    LTM_SYM_ZERO,
    LTM_SYM_POS,
    LTM_SYM_NEG
  } ltm_sym_e;

endpackage

/* hw/ltm_sync3.sv */
// Three-stage input synchroniser; a change passes once stages two and three agree.
// Assumes asynchronous level inputs, one bit per lane.
`timescale 1ns/1ps
`default_nettype none
module ltm_sync3
  import ltm_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] agreed;
  } ltm_sync_s;

  ltm_sync_s q;
  ltm_sync_s d;

  always_comb begin
    d = q;
    d.s1 = async_i;
    d.s2 = q.s1;
    d.s3 = q.s2;
    d.agreed = (q.s2 & q.s3) | (q.agreed & (q.s2 | q.s3));
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign sync_o = q.agreed;

endmodule
`default_nettype wire

/* hw/ltm_terminal.sv */
// Terminal end: makes the transmit clock, launches rail data, drives the off pin.
// Assumes the user presents one bit pair per bit period and takes the ready pulse.
`timescale 1ns/1ps
`default_nettype none
module ltm_terminal
  import ltm_pkg::*;
#(
  parameter int unsigned HALF_PERIOD = LTM_TERM_HALF_PERIOD
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  ltm_link_if.terminal_mp link,
  input wire logic host_mode_i,
  input wire logic tx_off_req_i,
  input wire logic single_rail_i,
  input wire logic sample_rising_i,
  input wire logic monitor_used_i,
  input wire logic pos_bit_i,
  input wire logic neg_bit_i,
  output logic bit_ready_o
);

  localparam int unsigned DIV_W = $clog2(HALF_PERIOD + 1);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(HALF_PERIOD - 1);

  typedef struct packed {
    logic [DIV_W-1:0] div;
    logic clk;
    logic pos;
    logic neg;
    logic off;
    logic mon_used;
    logic ready;
  } ltm_term_s;

  ltm_term_s q;
  ltm_term_s d;
  logic launch;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = q;
    d.ready = 1'b0;
    launch = 1'b0;
    if (q.div == DIV_LAST) begin
      d.div = '0;
      d.clk = ~q.clk;
      launch = sample_rising_i ? q.clk : ~q.clk;
    end else begin
      d.div = q.div + 1'b1;
    end
    if (launch) begin
      d.pos = pos_bit_i;
      d.neg = single_rail_i ? 1'b0 : neg_bit_i;
      d.ready = 1'b1;
    end
    // Off pin low in register mode
    d.off = host_mode_i ? 1'b0 : tx_off_req_i;
    d.mon_used = monitor_used_i;
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.tx_line_clock = q.clk;
  assign link.tx_positive_rail = q.pos;
  assign link.tx_negative_rail = q.neg;
  assign link.transmitter_off_input = q.off;
  assign link.monitor_used = q.mon_used;
  assign bit_ready_o = q.ready;

endmodule
`default_nettype wire

/* sim/ltm_link_monitor.sv */
// Checker on the link pins between the terminal and the device.
// Assumes a terminal half period of 4 cycles and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module ltm_link_monitor (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic tx_line_clock,
  input wire logic tx_positive_rail,
  input wire logic tx_negative_rail,
  input wire logic transmitter_off_input,
  input wire logic line_out_a,
  input wire logic line_out_a_oe,
  input wire logic line_out_b,
  input wire logic line_out_b_oe
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  ////////////////////////////////////////////////////////////
  a_off_tristate: assert property (transmitter_off_input [*6]
    |-> !line_out_a_oe && !line_out_b_oe) else $error("off pin left line driven");
  a_oe_paired: assert property (
    line_out_a_oe == line_out_b_oe) else $error("line enables differ");
  a_released_quiet: assert property (
    !line_out_a_oe |-> !line_out_a && !line_out_b) else $error("data while off");
  a_no_dual_pulse: assert property (
    !(line_out_a && line_out_b)) else $error("both pulse lines high");
  a_pos_cause: assert property (
    $rose(line_out_a) |-> $past(tx_positive_rail, 4)) else $error("stray positive pulse");
  a_neg_cause: assert property (
    $rose(line_out_b) |-> $past(tx_negative_rail, 4)) else $error("stray negative pulse");
  a_symbol_holds: assert property (
    $rose(line_out_a) |=> line_out_a [*2]) else $error("symbol too short");
  a_clock_half: assert property (
    $changed(tx_line_clock) |=> $stable(tx_line_clock) [*3]) else $error("clock too fast");
  c_pos_pulse: cover property ($rose(line_out_a));
  c_neg_pulse: cover property ($rose(line_out_b));
  c_line_off: cover property ($fell(line_out_a_oe));
endmodule
`default_nettype wire

/* sim/ltm_tb_top.sv */
// Testbench joining terminal and device over the link interface.
// Assumes the monitor loop is connected and both ends start in register mode.
`timescale 1ns/1ps
`default_nettype none
module ltm_tb_top;
  import ltm_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic off_req = 1'b0;
  logic single = 1'b0;
  logic rising = 1'b0;
  logic pos = 1'b0;
  logic neg = 1'b0;
  logic term_host = 1'b1;
  logic dev_host = 1'b1;
  logic wr = 1'b0;
  logic rdq = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] rd;
  logic ready;
  logic fault;
  logic irq;
  logic [1:0] h0;
  logic [1:0] ho;
  integer miscompares = 0;
  integer samples_checked = 0;
  integer seed = 2214;
  integer m;
  ltm_link_if link ();
  always #5 clk_i = ~clk_i;
  ltm_terminal #(.HALF_PERIOD(4)) u_ltm_terminal (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .link(link), .host_mode_i(term_host), .tx_off_req_i(off_req), .single_rail_i(single),
    .sample_rising_i(rising), .monitor_used_i(1'b1), .pos_bit_i(pos), .neg_bit_i(neg),
    .bit_ready_o(ready));
  ltm_device #(.FAULT_PERIODS(8)) u_ltm_device (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .link(link), .host_mode_i(dev_host), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(wr), .reg_read_i(rdq), .reg_rdata_o(rdata),
    .drive_fault_flag_o(fault), .irq_o(irq));
  ltm_link_monitor u_ltm_link_monitor (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .tx_line_clock(link.tx_line_clock), .tx_positive_rail(link.tx_positive_rail),
    .tx_negative_rail(link.tx_negative_rail),
    .transmitter_off_input(link.transmitter_off_input),
    .line_out_a(link.line_out_a), .line_out_a_oe(link.line_out_a_oe),
    .line_out_b(link.line_out_b), .line_out_b_oe(link.line_out_b_oe));
  ////////////////////////////////////////////////////////////
  task automatic chk_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t flag got %b exp %b", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t value got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr <= a;
    rdq <= 1'b1;
    @(posedge clk_i);
    rdq <= 1'b0;
    #1 d = rdata;
  endtask
  // Line symbol {a, b} for a rail pair {pos, neg}
  function automatic logic [1:0] exp_sym(input logic [1:0] pn, input logic s);
    exp_sym = {pn[1] & (s | ~pn[0]), pn[0] & ~pn[1] & ~s};
  endfunction
  task automatic stream(input int n);
    int k;
    int t;
    for (k = 0; k < n; k++) begin
      t = 0;
      do begin
        @(negedge clk_i);
        t++;
      end while (ready !== 1'b1 && t < 40);
      chk_bit(ready, 1'b1);
      ho = h0;
      h0 = {pos, neg};
      @(posedge clk_i);
      {pos, neg} <= 2'($random(seed));
      repeat (3) @(negedge clk_i);
      if (k > 2) begin
        chk_bit(link.line_out_a_oe, 1'b1);
        chk_byte({6'h00, link.line_out_a, link.line_out_b},
          {6'h00, exp_sym(ho, m[0])});
      end
    end
    @(posedge clk_i);
  endtask
  task automatic report_and_stop;
    $display("Mismatches %0d in %0d checks", miscompares, samples_checked);
    if (miscompares == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #200000;
    miscompares++;
    report_and_stop;
  end
  initial begin
    cycles(16);
    reset_n_i <= 1'b1;
    reg_rd(LTM_ADDR_CTRL, rd);
    chk_byte(rd, LTM_CTRL_RESET);
    reg_rd(4'hf, rd);
    chk_byte(rd, 8'h00);
    // Falling, single with live negative rail, rising, rising single,
    // rise bit set outside register mode; rails quiet across each switch
    for (m = 0; m < 5; m++) begin
      {pos, neg} <= 2'b00;
      cycles(24);
      reg_wr(LTM_ADDR_CTRL, {5'h00, m[0], m[1] | m[2], 1'b0});
      single <= m[0] & m[1];
      rising <= m[1];
      dev_host <= ~m[2];
      cycles(24);
      stream(30);
    end
    {pos, neg} <= 2'b00;
    dev_host <= 1'b1;
    rising <= 1'b1;
    cycles(24);
    // Fresh pulse restarts the quiet count before old events are cleared
    pos <= 1'b1;
    cycles(32);
    reg_wr(LTM_ADDR_CLEAR, 8'h03);
    reg_wr(LTM_ADDR_ENABLE, 8'h03 & 8'h01);
    off_req <= 1'b1;
    cycles(10);
    chk_bit(link.transmitter_off_input, 1'b0);
    chk_bit(link.line_out_a_oe, 1'b1);
    term_host <= 1'b0;
    cycles(10);
    chk_bit(link.line_out_a_oe, 1'b0);
    chk_bit(link.line_out_b_oe, 1'b0);
    cycles(100);
    chk_bit(fault, 1'b1);
    chk_bit(irq, 1'b1);
    reg_rd(LTM_ADDR_STATE, rd);
    chk_byte(rd, (8'h01 << LTM_ST_FAULT_BIT) | (8'h01 << LTM_ST_OFF_PIN_BIT)
      | (8'h01 << LTM_ST_HOST_BIT));
    reg_wr(LTM_ADDR_STATUS, 8'hff);
    reg_rd(LTM_ADDR_STATUS, rd);
    chk_byte(rd, 8'h01);
    reg_wr(LTM_ADDR_CLEAR, 8'h01);
    cycles(2);
    chk_bit(irq, 1'b0);
    reg_wr(LTM_ADDR_CTRL, 8'h01);
    off_req <= 1'b0;
    pos <= 1'b1;
    cycles(20);
    chk_bit(link.line_out_a_oe, 1'b0);
    chk_bit(fault, 1'b1);
    reg_wr(LTM_ADDR_CTRL, 8'h00);
    cycles(30);
    chk_bit(fault, 1'b0);
    reg_rd(LTM_ADDR_STATUS, rd);
    chk_byte(rd, 8'h02);
    chk_bit(irq, 1'b0);
    report_and_stop;
  end
endmodule
`default_nettype wire
